/* File: design/wdg_pkg.sv */
// Purpose: shared constants and types for the watchdog timer
// Assumes: mclk at 40 MHz; oscillator modelled as a divided enable
// Notes:   register map is byte addressed on the plain register port
package wdg_pkg;
    // =========================================================
    // timing
    localparam int unsigned CLK_HZ          = 40000000;
    localparam int unsigned LFOSC_HZ        = 31000;
    localparam int unsigned TICK_US         = 1000;
    // one nominal 1 ms tick in mclk cycles
    localparam int unsigned TICK_CYC        = CLK_HZ / 1000000 * TICK_US;
    // oscillator start-up timer length in mclk cycles
    localparam int unsigned OST_CYC         = 1024;
    // =========================================================
    // register map (byte addresses)
    localparam logic [7:0]  ADDR_CTRL       = 8'h00;
    localparam logic [7:0]  ADDR_STAT       = 8'h04;
    localparam logic [7:0]  ADDR_MASK       = 8'h08;
    localparam logic [7:0]  ADDR_COUNT      = 8'h0c;
    // control fields
    localparam int unsigned CTRL_EN_BIT     = 0;
    localparam int unsigned CTRL_PS_LSB     = 1;
    localparam int unsigned PS_W            = 5;
    // period select 2^ps ms; 01011 gives 2048 ms, the nominal 2 s
    localparam logic [4:0]  PS_RESET        = 5'h0b;
    localparam logic [4:0]  PS_MAX          = 5'h12;
    localparam int unsigned CNT_W           = 19;
    // status bits
    localparam int unsigned ST_TIMEOUT      = 0;
    localparam int unsigned ST_WAKE         = 1;
    localparam int unsigned ST_W            = 2;

    typedef enum logic [1:0]
    {
        WDG_CFG_OFF  = 2'b00,
        WDG_CFG_SW   = 2'b01,
        WDG_CFG_NOSL = 2'b10,
        WDG_CFG_ON   = 2'b11
    } wdg_cfg_t;

    typedef struct packed
    {
        logic clear_instr;
        logic sleep;
        logic osc_fail;
        logic xtal_mode;
    } wdg_core_t;
endpackage

/* File: design/wdg_tick.sv */
// Purpose: 1 ms tick enable derived from mclk, standing in for the slow oscillator
// Assumes: one clock domain
// Notes:   tick is a one-cycle enable
module wdg_tick
(
    // clock and reset
    input  wire logic mclk,
    input  wire logic rst_b,
    // tick output
    output logic      tick
);
    logic [15:0] div;
    logic [15:0] next_div;

    always_comb
    begin
        if (div == 16'(wdg_pkg::TICK_CYC - 1))
            next_div = 16'h0000;
        else
            next_div = div + 16'h0001;
    end

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            div <= 16'h0000;
        else
            div <= next_div;
    end

    // free-running: never gated by the system clock selection
    assign tick = (div == 16'(wdg_pkg::TICK_CYC - 1));
endmodule

/* File: design/wdg_timer.sv */
// Purpose: watchdog timer with four operating modes, sleep handling and a register port
// Assumes: core events arrive synchronous to mclk as one-cycle pulses or levels
// Notes:   time-out while awake resets the device; asleep it wakes the device
// How it works
// - count on a 1 ms tick from the slow oscillator, independent of system clock
// - config 11 keeps the watchdog active always, asleep too
// - config 10 is active awake and disabled in sleep
// - config 01 follows the software enable bit; sleep does not change it
// - config 00 disables the watchdog regardless of anything else
// - period select chooses the time-out, 1 ms up to 256 s nominal
// - after reset the period select gives about 2 s
// - count clears on reset, clear instr, sleep edges, osc fail, disable, start-up
// - on wake the count clears and stays clear through crystal start-up
// - after the sleep-entry clear, counting resumes if enabled in sleep
// - time-out in sleep wakes the device and updates timeout and powerdown flags
// - internal oscillator divider changes leave the count untouched
module wdg_timer
(
    // clock and reset
    input  wire logic                 mclk,
    input  wire logic                 rst_b,
    // configuration and core events
    input  wire logic [1:0]           wdt_mode_cfg,
    input  wire wdg_pkg::wdg_core_t   core,
    input  wire logic [3:0]           int_osc_freq_sel,
    // register port
    input  wire logic [7:0]           reg_addr,
    input  wire logic [31:0]          reg_wdata,
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    output logic      [31:0]          reg_rdata,
    // results
    output logic                      wdt_reset,
    output logic                      wdt_wake,
    output logic                      timeout_flag,
    output logic                      powerdown_flag,
    output logic                      irq
);
    // =========================================================
    // tick
    logic tick;

    wdg_tick u_tick
    (
        .mclk  (mclk),
        .rst_b (rst_b),
        .tick  (tick)
    );

    // =========================================================
    // registers and state
    logic                     sw_wdt_enable;
    logic [4:0]               wdt_period_select;
    logic [wdg_pkg::ST_W-1:0] stat;
    logic [wdg_pkg::ST_W-1:0] mask;
    logic [wdg_pkg::CNT_W-1:0] cnt;
    logic [10:0]              osc_startup_timer;
    logic                     sleep_q;
    logic                     tmo_q;
    logic                     pd_q;

    logic                     next_sw_wdt_enable;
    logic [4:0]               next_wdt_period_select;
    logic [wdg_pkg::ST_W-1:0] next_stat;
    logic [wdg_pkg::ST_W-1:0] next_mask;
    logic [wdg_pkg::CNT_W-1:0] next_cnt;
    logic [10:0]              next_ost;
    logic                     next_tmo_q;
    logic                     next_pd_q;
    logic [31:0]              next_rdata;

    logic                     active;
    logic                     enter_sleep;
    logic                     exit_sleep;
    logic                     hold_clear;
    logic [wdg_pkg::CNT_W-1:0] limit;
    logic                     expire;
    logic [wdg_pkg::ST_W-1:0] ev;

    wdg_pkg::wdg_cfg_t cfg;
    assign cfg = wdg_pkg::wdg_cfg_t'(wdt_mode_cfg);

    always_comb
    begin
        unique case (cfg)
            wdg_pkg::WDG_CFG_ON:   active = 1'b1;
            wdg_pkg::WDG_CFG_NOSL: active = !core.sleep;
            wdg_pkg::WDG_CFG_SW:   active = sw_wdt_enable;
            wdg_pkg::WDG_CFG_OFF:  active = 1'b0;
        endcase
    end

    assign enter_sleep = core.sleep && !sleep_q;
    assign exit_sleep  = !core.sleep && sleep_q;
    // int_osc_freq_sel feeds nothing: the count ignores it
    assign hold_clear  = core.clear_instr || enter_sleep || exit_sleep
                         || core.osc_fail || !active || (osc_startup_timer != 11'h000);
    // period is 2^ps ticks
    assign limit  = wdg_pkg::CNT_W'(1) << wdt_period_select;
    // a shorter period written mid-count still expires on the next tick, no wrap
    assign expire = active && !hold_clear && tick && (cnt >= limit - 1'b1);
    assign ev[wdg_pkg::ST_TIMEOUT] = expire && !core.sleep;
    assign ev[wdg_pkg::ST_WAKE]    = expire && core.sleep;

    // =========================================================
    // next-state logic
    always_comb
    begin
        next_sw_wdt_enable     = sw_wdt_enable;
        next_wdt_period_select = wdt_period_select;
        next_mask              = mask;
        next_tmo_q             = tmo_q;
        next_pd_q              = pd_q;
        next_ost               = osc_startup_timer;
        next_rdata             = 32'h0000_0000;
        if (reg_wr && reg_addr == wdg_pkg::ADDR_CTRL)
        begin
            next_sw_wdt_enable = reg_wdata[wdg_pkg::CTRL_EN_BIT];
            // clamp so the longest selection stays at 256 s nominal
            if (reg_wdata[wdg_pkg::CTRL_PS_LSB +: wdg_pkg::PS_W] > wdg_pkg::PS_MAX)
                next_wdt_period_select = wdg_pkg::PS_MAX;
            else
                next_wdt_period_select = reg_wdata[wdg_pkg::CTRL_PS_LSB +: wdg_pkg::PS_W];
        end
        if (reg_wr && reg_addr == wdg_pkg::ADDR_MASK)
            next_mask = reg_wdata[wdg_pkg::ST_W-1:0];
        // set wins over write-one-to-clear
        next_stat = stat;
        if (reg_wr && reg_addr == wdg_pkg::ADDR_STAT)
            next_stat = stat & ~reg_wdata[wdg_pkg::ST_W-1:0];
        next_stat = next_stat | ev;
        // crystal start-up holds the count clear after wake
        if (exit_sleep && core.xtal_mode)
            next_ost = 11'(wdg_pkg::OST_CYC);
        else if (osc_startup_timer != 11'h000)
            next_ost = osc_startup_timer - 11'h001;
        // counting resumes once hold_clear drops, asleep included if still active
        if (hold_clear || expire)
            next_cnt = '0;
        else if (tick)
            next_cnt = cnt + 1'b1;
        else
            next_cnt = cnt;
        // flags: clear instr sets both; sleep entry sets timeout, clears powerdown; time-out clears timeout
        if (core.clear_instr)
        begin
            next_tmo_q = 1'b1;
            next_pd_q  = 1'b1;
        end
        if (enter_sleep)
        begin
            next_tmo_q = 1'b1;
            next_pd_q  = 1'b0;
        end
        if (ev[wdg_pkg::ST_WAKE])
        begin
            next_tmo_q = 1'b0;
            next_pd_q  = 1'b0;
        end
        if (ev[wdg_pkg::ST_TIMEOUT])
        begin
            next_tmo_q = 1'b0;
            next_pd_q  = 1'b1;
        end
        if (reg_rd)
        begin
            unique case (reg_addr)
                wdg_pkg::ADDR_CTRL:  next_rdata = {26'h0, wdt_period_select, sw_wdt_enable};
                wdg_pkg::ADDR_STAT:  next_rdata = {30'h0, stat};
                wdg_pkg::ADDR_MASK:  next_rdata = {30'h0, mask};
                wdg_pkg::ADDR_COUNT: next_rdata = {13'h0, cnt};
                default:             next_rdata = 32'h0000_0000;
            endcase
        end
    end

    // =========================================================
    // registers
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sw_wdt_enable     <= 1'b0;
            wdt_period_select <= wdg_pkg::PS_RESET;
            stat              <= '0;
            mask              <= '0;
            cnt               <= '0;
            osc_startup_timer               <= 11'h000;
            sleep_q           <= 1'b0;
            tmo_q             <= 1'b1;
            pd_q              <= 1'b1;
            reg_rdata         <= 32'h0000_0000;
            wdt_reset         <= 1'b0;
            wdt_wake          <= 1'b0;
        end
        else
        begin
            sw_wdt_enable     <= next_sw_wdt_enable;
            wdt_period_select <= next_wdt_period_select;
            stat              <= next_stat;
            mask              <= next_mask;
            cnt               <= next_cnt;
            osc_startup_timer               <= next_ost;
            sleep_q           <= core.sleep;
            tmo_q             <= next_tmo_q;
            pd_q              <= next_pd_q;
            reg_rdata         <= next_rdata;
            wdt_reset         <= ev[wdg_pkg::ST_TIMEOUT];
            wdt_wake          <= ev[wdg_pkg::ST_WAKE];
        end
    end

    assign timeout_flag   = tmo_q;
    assign powerdown_flag = pd_q;
    assign irq            = |(stat & mask);

    // =========================================================
    // checks
    sequence s_sleep_expire;
        expire && core.sleep;
    endsequence

    // wake on a crystal clock: start-up timer must run
    sequence s_xtal_wake;
        exit_sleep && core.xtal_mode;
    endsequence

    // a tick that the count should take while asleep
    sequence s_asleep_tick;
        core.sleep && active && tick && !hold_clear;
    endsequence

    AST_OFF_NO_COUNT: assert property (@(posedge mclk) disable iff (!rst_b)
        (wdt_mode_cfg == 2'b00) |=> (cnt == '0))
        else $error("count moved while disabled");
    AST_ON_ACTIVE: assert property (@(posedge mclk) disable iff (!rst_b)
        (wdt_mode_cfg == 2'b11) |-> active)
        else $error("always-on mode not active");
    AST_NOSL_SLEEP: assert property (@(posedge mclk) disable iff (!rst_b)
        (wdt_mode_cfg == 2'b10) |-> (active == !core.sleep))
        else $error("off-in-sleep mode wrong");
    AST_SW_EN: assert property (@(posedge mclk) disable iff (!rst_b)
        (wdt_mode_cfg == 2'b01) |-> (active == sw_wdt_enable))
        else $error("software mode ignores enable");
    AST_CLEAR_INSTR: assert property (@(posedge mclk) disable iff (!rst_b)
        core.clear_instr |=> (cnt == '0))
        else $error("clear instruction did not clear count");
    AST_OST_HOLD: assert property (@(posedge mclk) disable iff (!rst_b)
        s_xtal_wake |=> (cnt == '0) [*8])
        else $error("count not held during start-up");
    AST_SLEEP_WAKE: assert property (@(posedge mclk) disable iff (!rst_b)
        s_sleep_expire |=> (wdt_wake && !wdt_reset && !timeout_flag && !powerdown_flag))
        else $error("sleep time-out did not wake");
    AST_AWAKE_RESET: assert property (@(posedge mclk) disable iff (!rst_b)
        (expire && !core.sleep) |=> (wdt_reset && !timeout_flag))
        else $error("awake time-out did not reset");
    AST_TICK_ONLY: assert property (@(posedge mclk) disable iff (!rst_b)
        (!tick && !$past(hold_clear)) |=> (cnt == $past(cnt)) || (cnt == '0))
        else $error("count moved without tick");
    AST_PERIOD: assert property (@(posedge mclk) disable iff (!rst_b)
        (wdt_reset || wdt_wake) |-> ($past(cnt) >= (19'h1 << $past(wdt_period_select)) - 19'h1))
        else $error("expiry not at period");
    AST_PS_RANGE: assert property (@(posedge mclk) disable iff (!rst_b)
        (wdt_period_select <= wdg_pkg::PS_MAX))
        else $error("period select beyond longest time-out");

    // sleep, wake and clear sources; divider change
    AST_OST_LOAD: assert property (@(posedge mclk) disable iff (!rst_b)
        s_xtal_wake |=> (osc_startup_timer != 11'h000))
        else $error("start-up timer not loaded on wake");
    AST_WAKE_CLEAR: assert property (@(posedge mclk) disable iff (!rst_b)
        exit_sleep |=> (cnt == '0))
        else $error("count not cleared on wake");
    AST_ENTRY_CLEAR: assert property (@(posedge mclk) disable iff (!rst_b)
        enter_sleep |=> (cnt == '0))
        else $error("count not cleared on sleep entry");
    AST_OSC_FAIL: assert property (@(posedge mclk) disable iff (!rst_b)
        core.osc_fail |=> (cnt == '0))
        else $error("count not cleared on oscillator fail");
    AST_FLAGS_CLEAR: assert property (@(posedge mclk) disable iff (!rst_b)
        (core.clear_instr && !enter_sleep) |=> (timeout_flag && powerdown_flag))
        else $error("clear instruction did not set flags");
    AST_NOSL_ASLEEP: assert property (@(posedge mclk) disable iff (!rst_b)
        ((wdt_mode_cfg == 2'b10) && core.sleep) |=> (cnt == '0))
        else $error("off-in-sleep mode counted asleep");
    AST_RESUME: assert property (@(posedge mclk) disable iff (!rst_b)
        s_asleep_tick |=> ((cnt == $past(cnt) + 19'h1) || wdt_wake))
        else $error("count did not resume in sleep");
    AST_DIV_CHANGE: assert property (@(posedge mclk) disable iff (!rst_b)
        ($changed(int_osc_freq_sel) && !tick && !hold_clear) |=> (cnt == $past(cnt)))
        else $error("divider change moved the count");

    // results leave their mark in status
    AST_STAT_TIMEOUT: assert property (@(posedge mclk) disable iff (!rst_b)
        wdt_reset |-> stat[wdg_pkg::ST_TIMEOUT])
        else $error("awake time-out not in status");
    AST_STAT_WAKE: assert property (@(posedge mclk) disable iff (!rst_b)
        wdt_wake |-> stat[wdg_pkg::ST_WAKE])
        else $error("sleep time-out not in status");
endmodule

/* File: sim/wdg_core_model.sv */
// Purpose: behavioural core that drives sleep, clear and fail events
// Assumes: bench requests arrive as one-cycle pulses after a rising edge
// Notes:   the core leaves sleep by itself when the watchdog wakes it
module wdg_core_model
(
    // clock and reset
    input  wire logic          mclk,
    input  wire logic          rst_b,
    // bench requests
    input  wire logic          clear_req,
    input  wire logic          sleep_req,
    input  wire logic          fail_req,
    input  wire logic          xtal_sel,
    // watchdog result
    input  wire logic          wdt_wake,
    // core events
    output wdg_pkg::wdg_core_t core
);
    timeunit 1ns;
    timeprecision 100ps;
    logic asleep;
    logic next_asleep;
    always_comb
    begin
        // a time-out in sleep resumes execution
        next_asleep = (asleep | sleep_req) & ~wdt_wake;
    end
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            asleep <= 1'b0;
        else
            asleep <= next_asleep;
    end
    // crystal clock: count held clear through start-up after wake
    assign core = '{clear_instr: clear_req, sleep: asleep, osc_fail: fail_req, xtal_mode: xtal_sel};
endmodule

/* File: sim/wdg_timer_tb_top.sv */
// Purpose: self-checking bench for the watchdog timer
// Assumes: 40 MHz mclk; one tick is 40000 cycles, so only a few ticks are run
// Notes:   mode, clear and sleep paths are observed through the count register
module wdg_timer_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic [1:0] wdt_mode_cfg = 2'b11;
    logic [3:0] int_osc_freq_sel = 4'h0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic clear_req = 1'b0;
    logic sleep_req = 1'b0;
    logic fail_req = 1'b0;
    logic [31:0] reg_rdata;
    logic wdt_reset, wdt_wake, timeout_flag, powerdown_flag, irq;
    wdg_pkg::wdg_core_t core;
    int num_errors = 0;
    int checks_done = 0;
    logic [31:0] v;
    always #12.5 mclk = ~mclk;
    wdg_core_model i_core (.mclk(mclk), .rst_b(rst_b), .clear_req(clear_req),
        .sleep_req(sleep_req), .fail_req(fail_req), .xtal_sel(1'b1), .wdt_wake(wdt_wake),
        .core(core));
    wdg_timer i_dut (.mclk(mclk), .rst_b(rst_b), .wdt_mode_cfg(wdt_mode_cfg), .core(core),
        .int_osc_freq_sel(int_osc_freq_sel), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .wdt_reset(wdt_reset),
        .wdt_wake(wdt_wake), .timeout_flag(timeout_flag), .powerdown_flag(powerdown_flag),
        .irq(irq));
    // ==========================================================
    // access and check tasks
    task automatic complete_run();
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
            num_errors++;
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask
    // bounded wait for one result pulse; a tick is 40000 cycles
    task automatic wait_pulse(input bit want_wake);
        int n;
        for (n = 0; n < 42000; n++)
        begin
            @(posedge mclk);
            #1;
            if ((want_wake ? wdt_wake : wdt_reset) === 1'b1)
                break;
        end
        if (n == 42000)
        begin
            chk("result pulse", 32'h0, 32'h1);
            complete_run();
        end
    endtask
    // ==========================================================
    // main sequence
    initial
    begin
        repeat (20) @(posedge mclk);
        rst_b <= 1'b1;
        chk("timeout_flag at reset", timeout_flag, 1'b1);
        chk("irq at reset", irq, 1'b0);
        rd(wdg_pkg::ADDR_CTRL, v);
        chk("ctrl reset", v, 32'(wdg_pkg::PS_RESET) << wdg_pkg::CTRL_PS_LSB);
        rd(8'h10, v);
        chk("unmapped read", v, 32'h0);
        // first tick in always-on mode while awake
        for (int i = 0; i < 22000; i++)
        begin
            rd(wdg_pkg::ADDR_COUNT, v);
            if (v !== 32'h0)
                break;
        end
        chk("count after one tick", v, 32'h1);
        int_osc_freq_sel <= 4'h7;
        rd(wdg_pkg::ADDR_COUNT, v);
        chk("count after divider change", v, 32'h1);
        wdt_mode_cfg <= 2'b10;
        rd(wdg_pkg::ADDR_COUNT, v);
        chk("count off-in-sleep awake", v, 32'h1);
        // enable first: software mode with the bit low would clear the count
        wr(wdg_pkg::ADDR_CTRL, 32'h17);
        wdt_mode_cfg <= 2'b01;
        rd(wdg_pkg::ADDR_COUNT, v);
        chk("count sw enabled", v, 32'h1);
        @(posedge mclk);
        clear_req <= 1'b1;
        @(posedge mclk);
        clear_req <= 1'b0;
        rd(wdg_pkg::ADDR_COUNT, v);
        chk("count after clear instr", v, 32'h0);
        @(posedge mclk);
        fail_req <= 1'b1;
        @(posedge mclk);
        fail_req <= 1'b0;
        rd(wdg_pkg::ADDR_COUNT, v);
        chk("count after osc fail", v, 32'h0);
        wr(wdg_pkg::ADDR_CTRL, 32'h00);
        wdt_mode_cfg <= 2'b00;
        rd(wdg_pkg::ADDR_CTRL, v);
        chk("ctrl sw off", v, 32'h0);
        // shortest period, software mode: awake expiry resets the device
        wr(wdg_pkg::ADDR_MASK, 32'h3);
        wdt_mode_cfg <= 2'b01;
        wr(wdg_pkg::ADDR_CTRL, 32'h01);
        wait_pulse(1'b0);
        chk("awake timeout_flag", timeout_flag, 1'b0);
        chk("awake powerdown_flag", powerdown_flag, 1'b1);
        // enter sleep in off-in-sleep mode first: count must stay clear
        wdt_mode_cfg <= 2'b10;
        sleep_req <= 1'b1;
        @(posedge mclk);
        sleep_req <= 1'b0;
        rd(wdg_pkg::ADDR_STAT, v);
        chk("status awake expiry", v, 32'h1);
        chk("irq unmasked", irq, 1'b1);
        wr(wdg_pkg::ADDR_MASK, 32'h0);
        #1;
        chk("irq masked", irq, 1'b0);
        wr(wdg_pkg::ADDR_STAT, 32'h1);
        wr(wdg_pkg::ADDR_MASK, 32'h3);
        #1;
        chk("irq after status clear", irq, 1'b0);
        rd(wdg_pkg::ADDR_COUNT, v);
        chk("count off-in-sleep asleep", v, 32'h0);
        // always-on keeps counting asleep; expiry wakes instead of reset
        wdt_mode_cfg <= 2'b11;
        wait_pulse(1'b1);
        chk("sleep timeout_flag", timeout_flag, 1'b0);
        chk("sleep powerdown_flag", powerdown_flag, 1'b0);
        chk("no reset in sleep", wdt_reset, 1'b0);
        rd(wdg_pkg::ADDR_STAT, v);
        chk("status sleep expiry", v, 32'h2);
        rd(wdg_pkg::ADDR_COUNT, v);
        chk("count held after wake", v, 32'h0);
        complete_run();
    end
endmodule
